/* rtl/sat_counter.sv */
// Eight-bit saturating error counter with clear and subtract.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/100ps
module sat_counter (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic inc_i,
    input wire logic clr_i,
    input wire logic sub_i,
    input wire logic [soft_err_pkg::CNT_W-1:0] sub_val_i,
    output logic [soft_err_pkg::CNT_W-1:0] count_o,
    output logic stepped_o
);
    import soft_err_pkg::*;

    logic [CNT_W-1:0] base;

    // A clear in the same cycle frees a saturated counter for the new error
    assign stepped_o = inc_i && (clr_i || (count_o != CNT_MAX));

    // Clear and subtract first, then a new error lands on top unless the count was 255 and not cleared
    always_comb begin
        if (clr_i) begin
            base = '0;
        end else if (sub_i) begin
            base = count_o - sub_val_i;
        end else begin
            base = count_o;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_o <= '0;
        end else begin
            count_o <= stepped_o ? base + 8'h01 : base;
        end
    end
endmodule : sat_counter

/* rtl/soft_error_count_report.sv */
// Soft error tally: ring-reported counters, report timer and report frame
// request, plus the host-side counter set behind an APB slave.
// Assumes error pulses and ring state inputs are from logic on clk_sys_i.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module soft_error_count_report #(
    parameter int TICK_CYCLES = soft_err_pkg::MS_CYCLES,
    parameter logic [47:0] COLLECTOR_ADDR = 48'h0000_0000_0001
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [soft_err_pkg::NUM_ERR-1:0] err_i,
    input wire logic inserted_i,
    input wire logic contention_i,
    input wire logic beacon_i,
    input wire logic purge_i,
    input wire logic autoremove_i,
    input wire logic param_load_i,
    input wire logic [15:0] param_ms_i,
    input wire logic [47:0] upstream_neighbour_addr_i,
    input wire logic [31:0] phys_drop_i,
    output logic rpt_req_o,
    output logic rpt_assured_o,
    output logic [15:0] rpt_header_o,
    output logic [47:0] rpt_dest_o,
    output logic [31:0] rpt_subvec_o,
    output logic [47:0] rpt_una_o,
    output logic [31:0] rpt_drop_o,
    output logic [55:0] rpt_counts_o,
    input wire logic tx_done_i,
    input wire logic tx_fail_i,
    output logic ring_ovf_o
);
    import soft_err_pkg::*;

    localparam int DIV_W = $clog2(TICK_CYCLES);

    function automatic logic [31:0] pack4(input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] c, input logic [7:0] d);
        pack4 = {d, c, b, a};
    endfunction : pack4

    logic normal;
    logic qualify;
    logic [CNT_W-1:0] ring_cnt [NUM_ERR];
    logic [CNT_W-1:0] host_cnt [NUM_ERR];
    logic [CNT_W-1:0] snap [NUM_ERR];
    logic [CNT_W-1:0] tally [NUM_ERR];
    logic [NUM_ERR-1:0] ring_step;
    logic [NUM_ERR-1:0] host_step;
    logic [NUM_ERR-1:0] host_to_max;
    logic any_ring_step;
    logic any_ring_left;
    logic sub_now;
    logic wr_en;
    logic fetch;
    logic addr_ok;
    logic [31:0] next_rdata;
    logic [15:0] period;
    logic [15:0] time_left;
    logic [DIV_W-1:0] div_cnt;
    logic ms_tick;
    report_state_type state;
    report_state_type next_state;

    // ----------------------------------------------------------------
    // Qualifying conditions
    // ----------------------------------------------------------------
    assign normal = !contention_i && !beacon_i && !purge_i;
    assign qualify = inserted_i && normal;

    // ----------------------------------------------------------------
    // Counter sets
    // ----------------------------------------------------------------
    assign sub_now = (state == RPT_SENDING) && tx_done_i;

    for (genvar i = 0; i < NUM_ERR; i++) begin : g_cnt
        sat_counter u_ring (
            .clk_sys_i(clk_sys_i),
            .rstn_i(rstn_i),
            .inc_i(err_i[i] && qualify),
            .clr_i(1'b0),
            .sub_i(sub_now),
            .sub_val_i(snap[i]),
            .count_o(ring_cnt[i]),
            .stepped_o(ring_step[i])
        );
        sat_counter u_host (
            .clk_sys_i(clk_sys_i),
            .rstn_i(rstn_i),
            .inc_i(err_i[i] && qualify),
            .clr_i(fetch),
            .sub_i(1'b0),
            .sub_val_i(8'h00),
            .count_o(host_cnt[i]),
            .stepped_o(host_step[i])
        );
        assign host_to_max[i] = host_step[i] && (host_cnt[i] == CNT_NEAR) && !fetch;
    end

    assign any_ring_step = |ring_step;

    always_comb begin
        any_ring_left = 1'b0;
        for (int i = 0; i < NUM_ERR; i++) begin
            if (ring_cnt[i] != snap[i]) begin
                any_ring_left = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Millisecond tick and report timer
    // ----------------------------------------------------------------
    assign ms_tick = (div_cnt == DIV_W'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= ms_tick ? '0 : div_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            period <= REPORT_TIME_MS;
        end else if (param_load_i && (param_ms_i != 16'h0000)) begin
            period <= param_ms_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            time_left <= '0;
        end else if (state != RPT_RUNNING && next_state == RPT_RUNNING) begin
            time_left <= period;
        end else if (state == RPT_RUNNING && ms_tick) begin
            time_left <= time_left - 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Report scheduling
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            RPT_IDLE: begin
                if (any_ring_step) begin
                    next_state = RPT_RUNNING;
                end
            end
            RPT_RUNNING: begin
                if (autoremove_i) begin
                    next_state = RPT_IDLE;
                end else if (ms_tick && time_left == 16'h0001) begin
                    next_state = RPT_PENDING;
                end
            end
            RPT_PENDING: begin
                if (qualify) begin
                    next_state = RPT_SENDING;
                end
            end
            RPT_SENDING: begin
                if (tx_done_i) begin
                    // An error counted on the done edge also needs a new report
                    next_state = (any_ring_left || any_ring_step) ? RPT_RUNNING : RPT_IDLE;
                end else if (tx_fail_i) begin
                    next_state = RPT_PENDING;
                end
            end
            default: next_state = RPT_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= RPT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Report frame contents
    // ----------------------------------------------------------------
    assign rpt_req_o = (state == RPT_SENDING);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_ERR; i++) begin
                snap[i] <= '0;
            end
        end else if (state == RPT_PENDING && qualify) begin
            for (int i = 0; i < NUM_ERR; i++) begin
                snap[i] <= ring_cnt[i];
            end
        end else if (sub_now) begin
            for (int i = 0; i < NUM_ERR; i++) begin
                snap[i] <= '0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rpt_header_o <= '0;
            rpt_subvec_o <= '0;
            rpt_dest_o <= '0;
            rpt_assured_o <= 1'b0;
            rpt_una_o <= '0;
            rpt_drop_o <= '0;
        end else if (state == RPT_PENDING && qualify) begin
            rpt_header_o <= {MV_REPORT, DCLASS_REPORT, SCLASS_REPORT};
            rpt_subvec_o <= {SV_UPSTREAM, SV_DROP, SV_ISO, SV_NONISO};
            rpt_dest_o <= COLLECTOR_ADDR;
            rpt_assured_o <= 1'b1;
            rpt_una_o <= upstream_neighbour_addr_i;
            rpt_drop_o <= phys_drop_i;
        end
    end

    always_comb begin
        rpt_counts_o = '0;
        for (int i = 0; i < NUM_ERR; i++) begin
            rpt_counts_o[i*8 +: 8] = snap[i];
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign addr_ok = (paddr_i == REG_CMD) || (paddr_i == REG_TALLY_LO) ||
                     (paddr_i == REG_TALLY_HI) || (paddr_i == REG_STATUS) ||
                     (paddr_i == REG_PERIOD) || (paddr_i == REG_RING_LO) ||
                     (paddr_i == REG_RING_HI);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign wr_en = psel_i && penable_i && pwrite_i && addr_ok;
    assign fetch = wr_en && (paddr_i == REG_CMD) && pwdata_i[CMD_FETCH_BIT];

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_ERR; i++) begin
                tally[i] <= '0;
            end
        end else if (fetch) begin
            for (int i = 0; i < NUM_ERR; i++) begin
                tally[i] <= host_cnt[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ring_ovf_o <= 1'b0;
        end else if (|host_to_max) begin
            ring_ovf_o <= 1'b1;
        end else if (wr_en && paddr_i == REG_STATUS && pwdata_i[ST_OVF_BIT]) begin
            ring_ovf_o <= 1'b0;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr_i)
            REG_TALLY_LO: next_rdata = pack4(tally[0], tally[1], tally[2], tally[3]);
            REG_TALLY_HI: next_rdata = pack4(tally[4], tally[5], tally[6], 8'h00);
            REG_STATUS: begin
                next_rdata[ST_OVF_BIT] = ring_ovf_o;
                next_rdata[ST_RUN_BIT] = (state == RPT_RUNNING);
                next_rdata[ST_PEND_BIT] = (state == RPT_PENDING);
                next_rdata[ST_SEND_BIT] = (state == RPT_SENDING);
            end
            REG_PERIOD: next_rdata = {time_left, period};
            REG_RING_LO: next_rdata = pack4(ring_cnt[0], ring_cnt[1], ring_cnt[2], ring_cnt[3]);
            REG_RING_HI: next_rdata = pack4(ring_cnt[4], ring_cnt[5], ring_cnt[6], 8'h00);
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    chk_ring_gate: assert property ((!qualify && !sub_now) |=>
        ring_cnt[0] == $past(ring_cnt[0])) else $error("ring count moved outside normal");
    chk_normal_def: assert property ((beacon_i || purge_i || contention_i) |->
        !any_ring_step) else $error("counted outside normal state");
    chk_saturate: assert property ((ring_cnt[1] == CNT_MAX && !sub_now) |=>
        ring_cnt[1] == CNT_MAX) else $error("counter wrapped");
    chk_timer_start: assert property ((state == RPT_IDLE && any_ring_step) |=>
        state == RPT_RUNNING && time_left == $past(period)) else $error("timer not started");
    chk_send_normal: assert property ((state == RPT_PENDING && !qualify) |=>
        state == RPT_PENDING) else $error("report sent outside normal");
    chk_subtract: assert property ((sub_now && !ring_step[0]) |=>
        ring_cnt[0] == $past(ring_cnt[0]) - $past(snap[0])) else $error("bad subtract");
    chk_retry: assert property ((state == RPT_SENDING && tx_fail_i && !tx_done_i) |=>
        state == RPT_PENDING) else $error("failed report not retried");
    chk_cancel: assert property ((state == RPT_RUNNING && autoremove_i) |=>
        state == RPT_IDLE) else $error("timer not cancelled");
    chk_period_load: assert property ((param_load_i && param_ms_i != 16'h0000) |=>
        period == $past(param_ms_i)) else $error("period not replaced");
    chk_frame_hdr: assert property (rpt_req_o |-> rpt_header_o == 16'h2960 &&
        rpt_subvec_o == 32'h020B_2D2E) else $error("bad report frame fields");
    chk_host_mirror: assert property ((err_i[2] && qualify && host_cnt[2] != CNT_MAX &&
        !fetch) |=> host_cnt[2] == $past(host_cnt[2]) + 8'h01) else $error("host count missed");
    chk_fetch_clear: assert property (fetch |=> tally[3] == $past(host_cnt[3]) &&
        host_cnt[3] <= 8'h01) else $error("fetch did not return and clear");
    chk_ovf_set: assert property (|host_to_max |=> ring_ovf_o) else $error("overflow missed");
    chk_no_restart: assert property ((state == RPT_RUNNING && any_ring_step && !ms_tick)
        |=> time_left == $past(time_left)) else $error("timer restarted");

    cov_report_sent: cover property (state == RPT_SENDING ##1 state != RPT_SENDING);
    cov_retry: cover property (state == RPT_SENDING && tx_fail_i);
    cov_fetch: cover property (fetch && host_cnt[0] != 8'h00);
    cov_cancel: cover property (state == RPT_RUNNING && autoremove_i);
endmodule : soft_error_count_report

/* shared/soft_err_pkg.sv */
// Constants, offsets and types for the soft error tally and report block.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
//
// Functional notes
// - Ring counter steps only on its error, inserted, normal state, below 255.
// - Normal state means no contention, no beacon and no ring purge.
// - Any ring counter increment starts the report timer.
// - Timer expiry queues the report; it is sent only in normal state.
// - After the report is sent, its counts are subtracted from the ring counters.
// - The report frame goes out with assured delivery, retried on failure.
// - Beacon auto-removal cancels a running report timer.
// - Timer period defaults to two seconds; MAC parameter frames may replace it.
// - Report frame uses vector 29, destination class 6, source class 0.
// - Report carries subvectors 02, 0B, 2D and 2E.
// - Two identical independent counter sets: one for ring, one for host.
// - Host fetches the host counters with the fetch tally command.
// - Host counters step under the same inserted and qualifying conditions.
// - A host counter stepping 254 to 255 sets the overflow indication.
// - Host counters clear to zero when the host fetches them.

package soft_err_pkg;
    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    localparam int NUM_ERR = 7;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_NEAR = 8'hFE;
    localparam int ERR_LINE = 0;
    localparam int ERR_BURST = 1;
    localparam int ERR_ARIFCI = 2;
    localparam int ERR_LOST = 3;
    localparam int ERR_COPIED = 4;
    localparam int ERR_CONGEST = 5;
    localparam int ERR_TOKEN = 6;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam logic [15:0] REPORT_TIME_MS = 16'h07D0;

    // ----------------------------------------------------------------
    // Report frame
    // ----------------------------------------------------------------
    localparam logic [7:0] MV_REPORT = 8'h29;
    localparam logic [3:0] DCLASS_REPORT = 4'h6;
    localparam logic [3:0] SCLASS_REPORT = 4'h0;
    localparam logic [7:0] SV_UPSTREAM = 8'h02;
    localparam logic [7:0] SV_DROP = 8'h0B;
    localparam logic [7:0] SV_ISO = 8'h2D;
    localparam logic [7:0] SV_NONISO = 8'h2E;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_TALLY_LO = 8'h04;
    localparam logic [7:0] REG_TALLY_HI = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_PERIOD = 8'h10;
    localparam logic [7:0] REG_RING_LO = 8'h14;
    localparam logic [7:0] REG_RING_HI = 8'h18;
    localparam int CMD_FETCH_BIT = 0;
    localparam int ST_OVF_BIT = 0;
    localparam int ST_RUN_BIT = 1;
    localparam int ST_PEND_BIT = 2;
    localparam int ST_SEND_BIT = 3;

    typedef enum logic [1:0] {
        RPT_IDLE,
        RPT_RUNNING,
        RPT_PENDING,
        RPT_SENDING
    } report_state_type;
endpackage : soft_err_pkg

/* tb/ring_tx_model.sv */
// Ring transmitter model: sends the queued report frame and confirms or refuses it.
// Assumes the report request is a level held until done or fail is seen.
`timescale 1ns/100ps
module ring_tx_model (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic rpt_req_i,
    input wire logic rpt_assured_i,
    input wire logic fail_i,
    input wire logic [7:0] delay_i,
    output logic tx_done_o,
    output logic tx_fail_o
);
    logic [7:0] wait_cnt;
    logic hold;

    // ----------------------------------------------------------------
    // Transmit, then confirm or refuse after delay_i cycles
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_cnt <= 8'h00;
            hold <= 1'b0;
            tx_done_o <= 1'b0;
            tx_fail_o <= 1'b0;
        end else begin
            tx_done_o <= 1'b0;
            tx_fail_o <= 1'b0;
            if (hold) begin
                hold <= rpt_req_i;
            end else if (rpt_req_i && rpt_assured_i) begin
                if (wait_cnt >= delay_i) begin
                    tx_done_o <= !fail_i;
                    tx_fail_o <= fail_i;
                    hold <= 1'b1;
                    wait_cnt <= 8'h00;
                end else begin
                    wait_cnt <= wait_cnt + 8'h01;
                end
            end
        end
    end
endmodule : ring_tx_model

/* tb/soft_error_count_report_tb.sv */
// Self-checking bench for the soft error tally and report block.
// Assumes zero-wait APB and a ring transmitter model on the report side.
`timescale 1ns/100ps
module soft_error_count_report_tb;
    import soft_err_pkg::*;
    localparam logic [47:0] DEST = 48'h0300_0000_0008;
    localparam logic [47:0] NBR_ADDR = 48'h4000_1234_5678;
    localparam logic [31:0] DROP_V = 32'hA5C3_0011;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, inserted, contention, beacon;
    logic purge, autoremove, param_load, rpt_req, rpt_assured, tx_done, tx_fail, fail, ring_ovf;
    logic rerr;
    logic [7:0] paddr, tx_delay;
    logic [31:0] pwdata, prdata, rdata, rpt_subvec, rpt_drop;
    logic [6:0] err;
    logic [15:0] param_ms, rpt_header;
    logic [47:0] rpt_dest, rpt_una;
    logic [55:0] rpt_counts;
    int n_errors = 0;
    int tests_run = 0;

    soft_error_count_report #(.TICK_CYCLES(10), .COLLECTOR_ADDR(DEST)) soft_error_count_report_i (
        .clk_sys_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .err_i(err), .inserted_i(inserted),
        .contention_i(contention), .beacon_i(beacon), .purge_i(purge),
        .autoremove_i(autoremove), .param_load_i(param_load), .param_ms_i(param_ms),
        .upstream_neighbour_addr_i(NBR_ADDR), .phys_drop_i(DROP_V), .rpt_req_o(rpt_req),
        .rpt_assured_o(rpt_assured), .rpt_header_o(rpt_header), .rpt_dest_o(rpt_dest),
        .rpt_subvec_o(rpt_subvec), .rpt_una_o(rpt_una), .rpt_drop_o(rpt_drop),
        .rpt_counts_o(rpt_counts), .tx_done_i(tx_done), .tx_fail_i(tx_fail),
        .ring_ovf_o(ring_ovf));

    ring_tx_model ring_tx_model_i (.clk_sys_i(clk), .rstn_i(rstn), .rpt_req_i(rpt_req),
        .rpt_assured_i(rpt_assured), .fail_i(fail), .delay_i(tx_delay),
        .tx_done_o(tx_done), .tx_fail_o(tx_fail));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Checks and closing report
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic give_up;
        n_errors++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        print_verdict();
    endtask : give_up

    // ----------------------------------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) give_up();
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        apb(a, 1'b0, 32'h0000_0000);
        check(64'(rdata & mask), 64'(exp));
    endtask : rd

    task automatic pulse(input int idx, input int n);
        @(posedge clk);
        err <= 7'(1 << idx);
        repeat (n - 1) @(posedge clk);
        @(posedge clk);
        err <= 7'h00;
    endtask : pulse

    task automatic wait_req(input logic lvl, input int lim);
        int n;
        n = 0;
        while (rpt_req !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (rpt_req !== lvl) give_up();
    endtask : wait_req

    task automatic hold_low(input int n);
        repeat (n) begin
            @(negedge clk);
            check_bit(rpt_req, 1'b0);
        end
    endtask : hold_low

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; err = 7'h00; inserted = 1'b1; contention = 1'b0; beacon = 1'b0;
        purge = 1'b0; autoremove = 1'b0; param_load = 1'b0; param_ms = 16'h0000;
        fail = 1'b0; tx_delay = 8'h14;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd(REG_STATUS, 32'h0, 32'hF);
        rd(REG_PERIOD, 32'h0000_07D0, 32'hFFFF);
        apb(8'h1C, 1'b1, 32'hFFFF_FFFF);
        check_bit(rerr, 1'b1);
        rd(8'h1C, 32'h0, 32'hFFFF_FFFF);
        check_bit(rerr, 1'b1);
        @(posedge clk);
        param_load <= 1'b1;
        param_ms <= 16'h0005;
        @(posedge clk);
        param_load <= 1'b0;
        rd(REG_PERIOD, 32'h0000_0005, 32'hFFFF);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            inserted <= (k != 0);
            contention <= (k == 1);
            beacon <= (k == 2);
            purge <= (k == 3);
            pulse(3, 2);
        end
        @(posedge clk);
        inserted <= 1'b1;
        purge <= 1'b0;
        rd(REG_RING_LO, 32'h0, 32'hFFFF_FFFF);
        rd(REG_STATUS, 32'h0, 32'h7);
        pulse(0, 3);
        rd(REG_STATUS, 32'h2, 32'hF);
        repeat (27) @(posedge clk);
        pulse(6, 1);
        @(posedge clk);
        contention <= 1'b1;
        hold_low(34);
        rd(REG_STATUS, 32'h4, 32'hF);
        @(posedge clk);
        contention <= 1'b0;
        wait_req(1'b1, 6);
        check(64'(rpt_header), 64'h2960);
        check(64'(rpt_dest), 64'(DEST));
        check(64'(rpt_subvec), 64'h020B_2D2E);
        check(64'(rpt_una), 64'(NBR_ADDR));
        check(64'(rpt_drop), 64'(DROP_V));
        check(64'(rpt_counts), 64'h0001_0000_0000_0003);
        check_bit(rpt_assured, 1'b1);
        pulse(0, 1);
        wait_req(1'b0, 40);
        check(64'(rpt_counts), 64'h0);
        rd(REG_RING_LO, 32'h0000_0001, 32'hFFFF_FFFF);
        rd(REG_RING_HI, 32'h0, 32'hFFFF_FFFF);
        rd(REG_STATUS, 32'h2, 32'hF);
        @(posedge clk);
        autoremove <= 1'b1;
        @(posedge clk);
        autoremove <= 1'b0;
        rd(REG_STATUS, 32'h0, 32'h7);
        hold_low(80);
        @(posedge clk);
        fail <= 1'b1;
        pulse(2, 1);
        wait_req(1'b1, 70);
        check(64'(rpt_counts), 64'h01_0001);
        wait_req(1'b0, 40);
        @(posedge clk);
        fail <= 1'b0;
        wait_req(1'b1, 10);
        check(64'(rpt_counts), 64'h01_0001);
        wait_req(1'b0, 40);
        rd(REG_RING_LO, 32'h0, 32'hFFFF_FFFF);
        apb(REG_CMD, 1'b1, 32'h1);
        rd(REG_TALLY_LO, 32'h0001_0004, 32'hFFFF_FFFF);
        rd(REG_TALLY_HI, 32'h0001_0000, 32'hFFFF_FFFF);
        @(posedge clk);
        param_load <= 1'b1;
        param_ms <= 16'h0064;
        @(posedge clk);
        param_load <= 1'b0;
        apb(REG_CMD, 1'b1, 32'h1);
        pulse(1, 254);
        rd(REG_STATUS, 32'h0, 32'h1);
        check_bit(ring_ovf, 1'b0);
        pulse(1, 1);
        rd(REG_STATUS, 32'h1, 32'h1);
        check_bit(ring_ovf, 1'b1);
        pulse(1, 5);
        rd(REG_RING_LO, 32'h0000_FF00, 32'hFFFF_FFFF);
        apb(REG_CMD, 1'b1, 32'h1);
        rd(REG_TALLY_LO, 32'h0000_FF00, 32'hFFFF_FFFF);
        apb(REG_CMD, 1'b1, 32'h1);
        rd(REG_TALLY_LO, 32'h0, 32'hFFFF_FFFF);
        apb(REG_STATUS, 1'b1, 32'h1);
        rd(REG_STATUS, 32'h0, 32'h1);
        print_verdict();
    end
endmodule : soft_error_count_report_tb
